// [include/switch_scan_pkg.sv]
package switch_scan_pkg;

  // ********************************************************
  // Channel layout
  // ********************************************************
  localparam int unsigned CH_COUNT  = 24;             // Switch inputs
  localparam int unsigned CH_W      = 5;              // Channel index width
  localparam logic [4:0]  CH_FIRST  = 5'h00;          // first_switch_input
  localparam logic [4:0]  CH_LAST   = 5'h17;          // last_switch_input
  localparam int unsigned LVL_W     = 3;              // Current code width
  localparam int unsigned HALF_CH   = 12;             // Channels per setup word
  localparam int unsigned SETUP_W   = HALF_CH * LVL_W;

  // ********************************************************
  // Current level codes
  // ********************************************************
  localparam logic [2:0] LVL_0MA  = 3'h0;
  localparam logic [2:0] LVL_1MA  = 3'h1;
  localparam logic [2:0] LVL_2MA  = 3'h2;
  localparam logic [2:0] LVL_5MA  = 3'h3;
  localparam logic [2:0] LVL_10MA = 3'h4;
  localparam logic [2:0] LVL_15MA = 3'h5;

  // ********************************************************
  // Cleaning setup field positions
  // ********************************************************
  localparam int unsigned CLN_LVL_LSB  = 0;           // Cleaning current code
  localparam int unsigned CLN_TIME_LSB = 3;           // Cleaning time code
  localparam int unsigned CLN_SETUP_W  = 6;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_MHZ        = 50;        // clk_sys_i rate
  localparam int unsigned CLK_KHZ        = 50000;
  localparam int unsigned ACT_BASE_US    = 64;        // Shortest active window
  localparam int unsigned ACT_BASE_CYC   = ACT_BASE_US * CLK_MHZ;
  localparam logic [2:0]  ACT_CODE_MAX   = 3'h5;      // 2048 us
  localparam int unsigned PER_BASE_MS    = 2;         // Shortest scan period
  localparam int unsigned PER_BASE_CYC   = PER_BASE_MS * CLK_KHZ;
  localparam logic [3:0]  PER_CODE_MAX   = 4'hB;      // 4096 ms
  localparam int unsigned STARTUP_US     = 500;       // wetting_startup_delay
  localparam int unsigned STARTUP_CYC    = STARTUP_US * CLK_MHZ;
  localparam int unsigned CLN_TRAN_US    = 100;       // cleaning_transition_delay
  localparam int unsigned CLN_TRAN_CYC   = CLN_TRAN_US * CLK_MHZ;
  localparam int unsigned MUX_SETTLE_CYC = 2;         // Continuous mux settle
  localparam int unsigned POLL_EDGE_CYC  = 2;         // Extra apply cycle and sample cycle in a window
  localparam int unsigned TMR_W          = 32;        // Timer load width

  // ********************************************************
  // Sequencer states
  // ********************************************************
  typedef enum logic [3:0] {
    S_IDLE,
    S_START,
    S_SELECT,
    S_APPLY,
    S_SAMPLE,
    S_NEXT,
    S_TRAN,
    S_CLEAN,
    S_END,
    S_WAIT
  } scan_state_t;

endpackage : switch_scan_pkg

// [include/timer_if.sv]
`timescale 1ns/10ps
// Start/expire link between the sequencer and one of its timers
interface timer_if #(parameter int unsigned W = 32);
  logic         start;   // Load pulse
  logic [W-1:0] load;    // Cycles until done
  logic         done;    // One-cycle expiry pulse
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : timer_if

// [design/scan_timer.sv]
`timescale 1ns/10ps
module scan_timer
  import switch_scan_pkg::*;
#(
  parameter int unsigned W = TMR_W
)(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  timer_if.tmr      tmr
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [W-1:0] cnt;   // Cycles left
    logic         done;  // Expiry pulse
  } tmr_t;

  tmr_t q;
  tmr_t d;

  // Down count; a fresh start overrides a running count
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (tmr.start)
    begin
      d.cnt = tmr.load;
    end
    else if (q.cnt != '0)
    begin
      d.cnt  = q.cnt - 1'b1;
      d.done = (q.cnt == W'(1));
    end
  end

  // Register the state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tmr.done = q.done;

endmodule : scan_timer

// [design/switch_scan_sequencer.sv]
`timescale 1ns/10ps
// Operation
// - Continuous: currents always on, scan 0..23
// - Per-channel current code from two setups
// - Startup delay after trigger before currents
// - Store sampled state as reference
// - First finished cycle always raises interrupt
// - Later cycles interrupt only on change
// - Status read acknowledges, clears, releases
// - Scan period 2 ms to 4096 ms
// - Zero-current channels still sampled
// - Polling: one source on at a time
// - Polling active window 64 to 2048 us
// - Polling samples at window end
// - Trigger starts polling
// - Polling interrupt gated per channel
// - Changes between windows go unseen
// - Cleaning adds second current step
// - Cleaning all together after transition delay
// - Cleaning pulses raise no interrupt
// - Cleaning level, time, channel mask
// - Release on chip select rise after read
module switch_scan_sequencer
  import switch_scan_pkg::*;
#(
  parameter int unsigned PER_BASE     = PER_BASE_CYC,  // 2 ms in cycles
  parameter int unsigned STARTUP      = STARTUP_CYC,   // Startup in cycles
  parameter int unsigned CLN_TRAN     = CLN_TRAN_CYC   // Transition in cycles
)(
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   trigger_i,
  input  wire logic                   stop_i,
  input  wire logic                   poll_mode_i,
  input  wire logic [CH_COUNT-1:0]    channel_enable_i,
  input  wire logic [SETUP_W-1:0]     wetting_level_setup_a_i,
  input  wire logic [SETUP_W-1:0]     wetting_level_setup_b_i,
  input  wire logic [3:0]             scan_period_i,
  input  wire logic [2:0]             active_window_field_i,
  input  wire logic                   contact_cleaning_pulse_i,
  input  wire logic [CLN_SETUP_W-1:0] cleaning_level_setup_i,
  input  wire logic [CH_COUNT-1:0]    cleaning_channel_mask_i,
  input  wire logic [CH_COUNT-1:0]    channel_irq_enable_i,
  input  wire logic                   comparator_i,
  input  wire logic                   int_stat_read_i,
  input  wire logic                   cs_rise_i,
  output logic      [CH_COUNT-1:0]    source_on_o,
  output logic                        cleaning_active_o,
  output logic      [LVL_W-1:0]       cleaning_level_o,
  output logic      [CH_W-1:0]        mux_sel_o,
  output logic                        int_n_o,
  output logic                        switch_change_flag_o,
  output logic      [CH_COUNT-1:0]    switch_result_o,
  output logic                        scan_busy_o
);

  // ********************************************************
  // Helpers
  // ********************************************************

  // Current code of one channel from the two setup words
  function automatic logic [LVL_W-1:0] level_of(input int unsigned idx);
    logic [2*SETUP_W-1:0] all;
    all = {wetting_level_setup_b_i, wetting_level_setup_a_i};
    return all[idx*LVL_W +: LVL_W];
  endfunction : level_of

  // Window length: base doubled per code step, codes above 2048 us clamp
  function automatic logic [TMR_W-1:0] window_cycles(input logic [2:0] code);
    logic [2:0] c;
    c = (code > ACT_CODE_MAX) ? ACT_CODE_MAX : code;
    return TMR_W'(ACT_BASE_CYC) << c;
  endfunction : window_cycles

  // One-hot channel select
  function automatic logic [CH_COUNT-1:0] onehot(input logic [CH_W-1:0] ch);
    return CH_COUNT'(1) << ch;
  endfunction : onehot

  // ********************************************************
  // Reset release
  // ********************************************************
  logic rst_meta_q;   // First stage, read only by the second
  logic rst_n_q;      // Released reset for all logic

  // Assert at once, release after two edges
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ********************************************************
  // Timers
  // ********************************************************
  timer_if #(.W(TMR_W)) step_tmr ();   // Startup, windows, cleaning
  timer_if #(.W(TMR_W)) per_tmr ();    // Scan period

  scan_timer #(.W(TMR_W)) u_step_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .tmr       (step_tmr)
  );

  scan_timer #(.W(TMR_W)) u_period_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_q),
    .tmr       (per_tmr)
  );

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    scan_state_t         st;      // Sequencer state
    logic [CH_W-1:0]     ch;      // Channel in hand
    logic                first;   // First cycle after trigger
    logic [CH_COUNT-1:0] result;  // Stored reference states
    logic [CH_COUNT-1:0] src;     // Source enables
    logic                clean;   // Cleaning step active
    logic                flag;    // switch_change_flag
    logic                pend;    // Interrupt pin held low
    logic                rd_seen; // Status read in this select
    logic                per_hit; // Period expired before scan end
  } seq_t;

  seq_t q;
  seq_t d;

  logic [CH_COUNT-1:0] cont_mask;  // Enabled channels with nonzero current
  logic [CH_COUNT-1:0] cln_mask;   // Channels taking the cleaning step
  logic [TMR_W-1:0]    per_len;    // Period length in cycles

  // Masks of channels that draw current
  always_comb
  begin
    cont_mask = '0;
    for (int unsigned i = 0; i < CH_COUNT; i++)
    begin
      // Zero code means no source but the channel is still sampled
      cont_mask[i] = channel_enable_i[i] && (level_of(i) != LVL_0MA);
    end
    cln_mask = cleaning_channel_mask_i & channel_enable_i;
  end

  // Period: 2 ms doubled per code step up to 4096 ms
  always_comb
  begin
    if (scan_period_i > PER_CODE_MAX)
    begin
      per_len = TMR_W'(PER_BASE) << PER_CODE_MAX;
    end
    else
    begin
      per_len = TMR_W'(PER_BASE) << scan_period_i;
    end
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb
  begin
    d              = q;
    step_tmr.start = 1'b0;
    step_tmr.load  = '0;
    per_tmr.start  = 1'b0;
    per_tmr.load   = '0;

    // Period may expire while a long scan is still running
    if (per_tmr.done)
    begin
      d.per_hit = 1'b1;
    end

    // Acknowledge first so that a new event below wins over it
    if (int_stat_read_i)
    begin
      d.rd_seen = 1'b1;
    end
    if (cs_rise_i)
    begin
      // Release only when the status was read during this select
      if (q.rd_seen || int_stat_read_i)
      begin
        d.flag = 1'b0;
        d.pend = 1'b0;
      end
      d.rd_seen = 1'b0;
    end

    unique case (q.st)
      // Waiting for a trigger
      S_IDLE:
      begin
        if (trigger_i)
        begin
          d.first        = 1'b1;
          step_tmr.start = 1'b1;
          step_tmr.load  = TMR_W'(STARTUP);
          d.st           = S_START;
        end
      end

      // Startup delay, then the first scan cycle opens
      S_START:
      begin
        if (step_tmr.done)
        begin
          // Continuous: every enabled source on together
          d.src         = poll_mode_i ? '0 : cont_mask;
          per_tmr.start = 1'b1;
          per_tmr.load  = per_len;
          d.per_hit     = 1'b0;
          d.ch          = CH_FIRST;
          d.st          = S_SELECT;
        end
      end

      // Route a channel to the comparator
      S_SELECT:
      begin
        if (!channel_enable_i[q.ch])
        begin
          d.st = S_NEXT;
        end
        else
        begin
          step_tmr.start = 1'b1;
          if (poll_mode_i)
          begin
            // Only this channel's source is on during its window
            d.src         = onehot(q.ch) & cont_mask;
            // Source stays on through apply and sample, so trim those cycles
            step_tmr.load = window_cycles(active_window_field_i)
                            - TMR_W'(POLL_EDGE_CYC);
          end
          else
          begin
            step_tmr.load = TMR_W'(MUX_SETTLE_CYC);
          end
          d.st = S_APPLY;
        end
      end

      // Current applied, wait out the window
      S_APPLY:
      begin
        if (step_tmr.done)
        begin
          d.st = S_SAMPLE;
        end
      end

      // Sample only here, so changes between windows are not seen
      S_SAMPLE:
      begin
        if (poll_mode_i)
        begin
          d.src = '0;
        end
        if (q.first)
        begin
          d.result[q.ch] = comparator_i;
        end
        else if (comparator_i != q.result[q.ch])
        begin
          d.result[q.ch] = comparator_i;
          d.flag         = 1'b1;
          if (channel_irq_enable_i[q.ch])
          begin
            d.pend = 1'b1;
          end
        end
        d.st = S_NEXT;
      end

      // Advance, or close the normal step after the last channel
      S_NEXT:
      begin
        if (q.ch != CH_LAST)
        begin
          d.ch = q.ch + 1'b1;
          d.st = S_SELECT;
        end
        else if (contact_cleaning_pulse_i && (cln_mask != '0))
        begin
          step_tmr.start = 1'b1;
          step_tmr.load  = TMR_W'(CLN_TRAN);
          d.st           = S_TRAN;
        end
        else
        begin
          d.st = S_END;
        end
      end

      // Transition delay before the cleaning step
      S_TRAN:
      begin
        if (step_tmr.done)
        begin
          // All cleaning channels switch on in the same cycle
          d.src   = poll_mode_i ? cln_mask : (q.src | cln_mask);
          d.clean = 1'b1;
          step_tmr.start = 1'b1;
          step_tmr.load  = window_cycles(
            cleaning_level_setup_i[CLN_TIME_LSB +: 3]);
          d.st = S_CLEAN;
        end
      end

      // Cleaning step, no sampling and no interrupt here
      S_CLEAN:
      begin
        if (step_tmr.done)
        begin
          d.clean = 1'b0;
          d.src   = poll_mode_i ? '0 : cont_mask;
          d.st    = S_END;
        end
      end

      // End of a scan cycle
      S_END:
      begin
        if (q.first)
        begin
          // Reference states ready: always tell the host once
          d.flag  = 1'b1;
          d.pend  = 1'b1;
          d.first = 1'b0;
        end
        d.st = S_WAIT;
      end

      // Wait for the next period tick
      S_WAIT:
      begin
        if (q.per_hit || per_tmr.done)
        begin
          per_tmr.start = 1'b1;
          per_tmr.load  = per_len;
          d.per_hit     = 1'b0;
          // Refresh continuous sources to follow setup changes
          d.src = poll_mode_i ? '0 : cont_mask;
          d.ch  = CH_FIRST;
          d.st  = S_SELECT;
        end
      end

      default:
      begin
        d.st = S_IDLE;
      end
    endcase

    // Stop drops every source and halts the scan
    if (stop_i)
    begin
      d.st    = S_IDLE;
      d.src   = '0;
      d.clean = 1'b0;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      q    <= '0;
      q.st <= S_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign source_on_o          = q.src;
  assign cleaning_active_o    = q.clean;
  assign cleaning_level_o     = cleaning_level_setup_i[CLN_LVL_LSB +: LVL_W];
  assign mux_sel_o            = q.ch;
  assign int_n_o              = ~q.pend;
  assign switch_change_flag_o = q.flag;
  assign switch_result_o      = q.result;
  assign scan_busy_o          = (q.st != S_IDLE);

endmodule : switch_scan_sequencer

// [bench/switch_scan_monitor.sv]
`timescale 1ns/10ps
// ****
// Port checker
// ****
module switch_scan_monitor
  import switch_scan_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   reset_n_i,
  input wire logic                   trigger_i,
  input wire logic                   stop_i,
  input wire logic                   poll_mode_i,
  input wire logic [CLN_SETUP_W-1:0] cleaning_level_setup_i,
  input wire logic                   int_stat_read_i,
  input wire logic                   cs_rise_i,
  input wire logic [CH_COUNT-1:0]    source_on_o,
  input wire logic                   cleaning_active_o,
  input wire logic [LVL_W-1:0]       cleaning_level_o,
  input wire logic [CH_W-1:0]        mux_sel_o,
  input wire logic                   int_n_o,
  input wire logic                   switch_change_flag_o,
  input wire logic [CH_COUNT-1:0]    switch_result_o,
  input wire logic                   scan_busy_o
);
  logic seen_q;  // Status read seen since last chip select rise

  // Read memory, so a bare chip select rise can be told apart
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i)
      seen_q <= 1'b0;
    else
      seen_q <= int_stat_read_i | (seen_q & ~cs_rise_i);

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // Startup quiet span, shorter than the shortened startup count
  sequence s_quiet;
    (source_on_o == '0)[*8];
  endsequence
  sequence s_clean_run;
    cleaning_active_o ##1 cleaning_active_o;
  endsequence

  property p_busy;
    trigger_i && !scan_busy_o && !stop_i |=> scan_busy_o;
  endproperty
  property p_start;
    $rose(scan_busy_o) && !poll_mode_i |-> s_quiet;
  endproperty
  property p_poll;
    scan_busy_o && poll_mode_i && !cleaning_active_o |-> $onehot0(source_on_o);
  endproperty
  property p_ack;
    cs_rise_i && seen_q |=> int_n_o && !switch_change_flag_o;
  endproperty
  property p_keep;
    cs_rise_i && !seen_q && !int_stat_read_i && !int_n_o |=> !int_n_o;
  endproperty
  property p_hold;
    !int_n_o && !cs_rise_i && !stop_i |=> !int_n_o;
  endproperty
  property p_flag;
    $fell(int_n_o) |-> switch_change_flag_o;
  endproperty
  property p_clean;
    s_clean_run |-> !$fell(int_n_o);
  endproperty
  property p_mux;
    scan_busy_o && $changed(mux_sel_o) |->
      (mux_sel_o == $past(mux_sel_o) + 5'h01) || (mux_sel_o == CH_FIRST);
  endproperty
  property p_lvl;
    cleaning_level_o == cleaning_level_setup_i[2:0];
  endproperty
  property p_idle;
    !scan_busy_o && !trigger_i |=> $stable(switch_result_o);
  endproperty

  a_busy: assert property (p_busy) else $error("trigger did not start scan");
  a_start: assert property (p_start) else $error("sources on before startup");
  a_poll: assert property (p_poll) else $error("several sources in polling");
  a_ack: assert property (p_ack) else $error("acknowledge did not release");
  a_keep: assert property (p_keep) else $error("released without read");
  a_hold: assert property (p_hold) else $error("interrupt dropped alone");
  a_flag: assert property (p_flag) else $error("interrupt without flag");
  a_clean: assert property (p_clean) else $error("interrupt in cleaning");
  a_mux: assert property (p_mux) else $error("channel order broken");
  a_lvl: assert property (p_lvl) else $error("cleaning level wrong");
  a_idle: assert property (p_idle) else $error("result moved while idle");
endmodule : switch_scan_monitor

bind switch_scan_sequencer switch_scan_monitor mon (.*);

// [bench/host_model.sv]
`timescale 1ns/10ps
// ****
// Host side: acknowledges a low interrupt
// ****
module host_model (
  input  wire logic       clk_i,
  input  wire logic       int_n_i,
  input  wire logic       ack_en_i,
  input  wire logic [3:0] gap_i,
  output logic            read_o,
  output logic            cs_rise_o
);
  // Status read inside the frame, chip select rise after a gap
  initial
  begin
    read_o = 1'b0;
    cs_rise_o = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (ack_en_i && !int_n_i)
      begin
        read_o <= 1'b1;
        @(posedge clk_i);
        read_o <= 1'b0;
        repeat (gap_i) @(posedge clk_i);
        cs_rise_o <= 1'b1;
        @(posedge clk_i);
        cs_rise_o <= 1'b0;
        repeat (2) @(posedge clk_i);
      end
    end
  end
endmodule : host_model

// [bench/switch_scan_sequencer_bench.sv]
`timescale 1ns/10ps
module switch_scan_sequencer_bench
  import switch_scan_pkg::*;
;
  typedef struct packed {
    logic        poll;  // Scan mode
    logic [23:0] en;    // Enabled channels
    logic [23:0] sw;    // Switch levels
    logic [23:0] res;   // Stored result after first cycle
  } row_t;
  localparam logic [23:0] NZ = 24'hFBEFFE;  // Channels with nonzero current
  row_t rows [4] = '{'{1'b0, 24'hFFFFFF, 24'hA5A5A5, 24'hA5A5A5},
                     '{1'b0, 24'h0000FF, 24'h5A5A5A, 24'hA5A55A},
                     '{1'b1, 24'h000081, 24'hFFFFFF, 24'hA5A5DB},
                     '{1'b1, 24'h800000, 24'h000000, 24'h25A5DB}};
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, trigger_i = 1'b0, stop_i = 1'b0;
  logic poll = 1'b0, contact_cleaning_pulse = 1'b0, cmp = 1'b0, host_en = 1'b0, b_cs = 1'b0;
  logic [23:0] en = '0, sw = '0, msk = '0, irq = 24'hFFFFFF;
  logic [35:0] wa = {{11{LVL_1MA}}, LVL_0MA};
  logic [35:0] wb = {2{LVL_15MA, LVL_10MA, LVL_5MA, LVL_2MA, LVL_1MA, LVL_0MA}};
  logic [5:0]  cls = 6'h00;
  logic [3:0]  per = 4'h0, gap = 4'h1;
  logic [2:0]  win = 3'h0;
  logic        rd, h_cs;
  logic [23:0] source_on_o, switch_result_o;
  logic [2:0]  cleaning_level_o;
  logic [4:0]  mux_sel_o;
  logic        cleaning_active_o, int_n_o, switch_change_flag_o, scan_busy_o;
  int          errors = 0, tests_run = 0, n = 0;

  always #10 clk_sys_i = ~clk_sys_i;
  // Switch bank seen through the comparator
  always @(posedge clk_sys_i) cmp <= sw[mux_sel_o];

  switch_scan_sequencer #(.PER_BASE(50), .STARTUP(10), .CLN_TRAN(5)) uut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .trigger_i(trigger_i),
    .stop_i(stop_i), .poll_mode_i(poll), .channel_enable_i(en),
    .wetting_level_setup_a_i(wa), .wetting_level_setup_b_i(wb),
    .scan_period_i(per), .active_window_field_i(win),
    .contact_cleaning_pulse_i(contact_cleaning_pulse), .cleaning_level_setup_i(cls),
    .cleaning_channel_mask_i(msk), .channel_irq_enable_i(irq),
    .comparator_i(cmp), .int_stat_read_i(rd), .cs_rise_i(h_cs | b_cs),
    .source_on_o(source_on_o), .cleaning_active_o(cleaning_active_o),
    .cleaning_level_o(cleaning_level_o), .mux_sel_o(mux_sel_o), .int_n_o(int_n_o),
    .switch_change_flag_o(switch_change_flag_o),
    .switch_result_o(switch_result_o), .scan_busy_o(scan_busy_o));
  host_model host (.clk_i(clk_sys_i), .int_n_i(int_n_o), .ack_en_i(host_en),
    .gap_i(gap), .read_o(rd), .cs_rise_o(h_cs));

  // ****
  // Shared tasks
  // ****
  task check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task go;
    @(posedge clk_sys_i) trigger_i <= 1'b1;
    @(posedge clk_sys_i) trigger_i <= 1'b0;
  endtask : go
  task halt;
    @(posedge clk_sys_i) stop_i <= 1'b1;
    @(posedge clk_sys_i) stop_i <= 1'b0;
  endtask : halt
  task wait_int(input int n);
    repeat (n) if (int_n_o !== 1'b0) @(negedge clk_sys_i);
  endtask : wait_int
  task ack;
    @(posedge clk_sys_i) host_en <= 1'b1;
    repeat (200) if (int_n_o !== 1'b1) @(negedge clk_sys_i);
    @(posedge clk_sys_i) host_en <= 1'b0;
    @(negedge clk_sys_i);
  endtask : ack
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // Watchdog well above the expected run length
  initial
  begin
    repeat (90000) @(posedge clk_sys_i);
    errors++;
    end_sim();
  end

  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    foreach (rows[i])
    begin
      @(posedge clk_sys_i) {poll, en, sw} <= {rows[i].poll, rows[i].en, rows[i].sw};
      go();
      wait_int(20000);
      check(switch_result_o, rows[i].res);
      check(switch_change_flag_o, 1'b1);
      if (!rows[i].poll)
        check(source_on_o, rows[i].en & NZ);
      ack();
      check(int_n_o, 1'b1);
      halt();
      $display("row %0d done", i);
    end
    // Polling window length on the last channel, code 1 doubles the base
    @(posedge clk_sys_i) win <= 3'h1;
    go();
    repeat (200) if (source_on_o[23] !== 1'b1) @(negedge clk_sys_i);
    n = 0;
    while (source_on_o[23] === 1'b1 && n < 20000)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    check(24'(n), 24'(2 * ACT_BASE_CYC));
    wait_int(100);
    ack();
    halt();
    $display("window test done");
    // Bare chip select rise, then changes with and without enable
    @(posedge clk_sys_i) {poll, en, sw, gap} <= {1'b0, 24'hFFFFFF, 24'h0, 4'h9};
    go();
    wait_int(3000);
    @(posedge clk_sys_i) b_cs <= 1'b1;
    @(posedge clk_sys_i) b_cs <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check(int_n_o, 1'b0);
    ack();
    @(posedge clk_sys_i) sw <= 24'h000008;
    wait_int(3000);
    check(int_n_o, 1'b0);
    check(switch_result_o, 24'h000008);
    ack();
    @(posedge clk_sys_i) {irq, sw} <= {24'hFFFFEF, 24'h000018};
    repeat (600) @(negedge clk_sys_i);
    check(int_n_o, 1'b1);
    check(switch_change_flag_o, 1'b1);
    check(switch_result_o, 24'h000018);
    halt();
    $display("change test done");
    // Cleaning step on one masked channel in continuous mode
    @(posedge clk_sys_i) {contact_cleaning_pulse, msk, cls} <= {1'b1, 24'h001000, 3'h0, LVL_10MA};
    go();
    repeat (3000) if (cleaning_active_o !== 1'b1) @(negedge clk_sys_i);
    check(source_on_o, 24'hFBFFFE);
    check(cleaning_level_o, LVL_10MA);
    wait_int(8000);
    check(switch_change_flag_o, 1'b1);
    check(int_n_o, 1'b0);
    check(cleaning_active_o, 1'b0);
    check(source_on_o, 24'hFBEFFE);
    ack();
    halt();
    $display("cleaning test done");
    // Reset in mid-run
    go();
    repeat (50) @(negedge clk_sys_i);
    @(posedge clk_sys_i) reset_n_i <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check(int_n_o, 1'b1);
    check(switch_result_o, 24'h0);
    check(scan_busy_o, 1'b0);
    @(posedge clk_sys_i) reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    $display("reset test done");
    end_sim();
  end
endmodule : switch_scan_sequencer_bench
